// ---- design/rct16_timer.v ----
// two 16-bit reload/capture timers, the second chainable and wake-capable, behind an AHB-Lite slave
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "rct_defines.vh"

module rct16_timer (
  input wire hclk, // system clock, 50 MHz
  input wire hresetn, // asynchronous reset, active low
  input wire hsel, // slave select
  input wire [7:0] haddr, // byte address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write when high
  input wire [2:0] hsize, // transfer size, words only
  input wire [31:0] hwdata, // write data
  input wire hready, // bus ready
  output wire hreadyout, // slave ready
  output wire hresp, // always OKAY
  output reg [31:0] hrdata, // read data
  input wire ext_clk_in, // external clock, asynchronous
  input wire lfo_clk_in, // low_freq_oscillator output, asynchronous
  input wire [1:0] capture_pin, // crossbar capture pins per timer, asynchronous
  input wire cmp0_event, // comparator 0 output, asynchronous
  input wire [3:0] clu_out, // configurable_logic_unit outputs, synchronous
  input wire low_power_mode, // device in suspend or snooze
  output wire [1:0] timer_irq, // interrupt per timer
  output wire [1:0] timer_overflow, // overflow pulse per timer
  output reg wake_req // wake pulse from the wake-capable timer
);

  wire acc = hsel & hready & htrans[1];
  reg wr_q;
  reg rdp_q;
  reg [2:0] a_q;
  reg map_q;
  reg [3:0] div12_q;
  reg [2:0] ext_div_q;
  reg [2:0] lfo_div_q;
  reg [3:0] clu_prev_q;
  wire ext_rise;
  wire lfo_rise;
  wire lfo_fall;
  wire [1:0] pin_fall;
  wire cmp_fall;
  wire [1:0] ovf_all;
  wire [15:0] c0_all;
  wire [15:0] c1_all;
  wire [31:0] cnt_all;
  wire [31:0] rld_all;

  assign hresp = 1'b0;
  // reads take one wait state so a write just before is already visible
  assign hreadyout = ~rdp_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rdp_q <= 1'b0;
      a_q <= 3'h0;
      map_q <= 1'b0;
    end else begin
      wr_q <= acc & hwrite;
      rdp_q <= acc & ~hwrite;
      if (acc) begin
        a_q <= haddr[4:2];
        map_q <= (haddr[7:5] == 3'h0) && (haddr[1:0] == 2'h0);
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rdp_q) begin
      hrdata <= 32'h00000000;
      if (map_q) begin
        case (a_q[1:0])
          `RCT_REG_CTRL0: hrdata <= {24'h000000, c0_all[8*a_q[2] +: 8]};
          `RCT_REG_CTRL1: hrdata <= {24'h000000, c1_all[8*a_q[2] +: 8]};
          `RCT_REG_COUNT: hrdata <= {16'h0000, cnt_all[16*a_q[2] +: 16]};
          default: hrdata <= {16'h0000, rld_all[16*a_q[2] +: 16]};
        endcase
      end
    end
  end

  // system clock / 12 tick
  wire tick_d12 = (div12_q == `RCT_DIV12_LAST);
  wire tick_ext = ext_rise & (ext_div_q == `RCT_DIV8_LAST);
  wire tick_lfo = lfo_rise & (lfo_div_q == `RCT_DIV8_LAST);
  wire [3:0] clu_fall = clu_prev_q & ~clu_out;

  // slow inputs pass two flops before anything reads them
  rct_sync_edge rct_sync_edge_ext_inst (
    .clk(hclk),
    .rst_n(hresetn),
    .async_in(ext_clk_in),
    .rise(ext_rise),
    .fall()
  );

  rct_sync_edge rct_sync_edge_lfo_inst (
    .clk(hclk),
    .rst_n(hresetn),
    .async_in(lfo_clk_in),
    .rise(lfo_rise),
    .fall(lfo_fall)
  );

  rct_sync_edge rct_sync_edge_pin0_inst (
    .clk(hclk),
    .rst_n(hresetn),
    .async_in(capture_pin[0]),
    .rise(),
    .fall(pin_fall[0])
  );

  rct_sync_edge rct_sync_edge_pin1_inst (
    .clk(hclk),
    .rst_n(hresetn),
    .async_in(capture_pin[1]),
    .rise(),
    .fall(pin_fall[1])
  );

  rct_sync_edge rct_sync_edge_cmp_inst (
    .clk(hclk),
    .rst_n(hresetn),
    .async_in(cmp0_event),
    .rise(),
    .fall(cmp_fall)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div12_q <= 4'h0;
      ext_div_q <= 3'h0;
      lfo_div_q <= 3'h0;
      clu_prev_q <= 4'h0;
    end else begin
      div12_q <= tick_d12 ? 4'h0 : div12_q + 4'h1;
      clu_prev_q <= clu_out;
      if (ext_rise) begin
        ext_div_q <= ext_div_q + 3'h1;
      end
      if (lfo_rise) begin
        lfo_div_q <= lfo_div_q + 3'h1;
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_tmr
      reg [15:0] cnt_q;
      reg [15:0] rld_q;
      reg hflag_q;
      reg lflag_q;
      reg lo_irq_en_q;
      reg cap_en_q;
      reg split_q;
      reg run_q;
      reg [1:0] xsel_q;
      reg [1:0] csel_q;
      reg [1:0] rsel_q;
      reg lsel_q;
      reg hsel_q;
      reg tirq_en_q;
      reg ovf_q;
      reg irq_q;
      reg [15:0] cnt_d;
      reg [15:0] rld_d;
      reg hset;
      reg lset;
      reg ovf_d;
      reg xtick;
      reg cap_fall;
      reg frc;
      wire hit = wr_q & map_q & (a_q[2] == i);
      wire w_c0 = hit & (a_q[1:0] == `RCT_REG_CTRL0);
      wire w_c1 = hit & (a_q[1:0] == `RCT_REG_CTRL1);
      wire w_cnt = hit & (a_q[1:0] == `RCT_REG_COUNT);
      wire w_rld = hit & (a_q[1:0] == `RCT_REG_RELOAD);
      // low_half_clock_select / high_half_clock_select high = system clock
      wire tick_lo = lsel_q | xtick;
      wire tick_hi = hsel_q | xtick;
      wire cap_hit = cap_en_q & ~split_q & cap_fall;

      always @* begin
        case (xsel_q)
          `RCT_XCLK_SYS_DIV12: xtick = tick_d12;
          `RCT_XCLK_EXT_DIV8: xtick = tick_ext;
          `RCT_XCLK_PARTNER: xtick = (i == 1) ? ovf_all[0] : tick_d12;
          default: xtick = tick_lfo;
        endcase
        case (csel_q)
          `RCT_CSEL_PIN: cap_fall = pin_fall[i];
          `RCT_CSEL_LFO: cap_fall = lfo_fall;
          `RCT_CSEL_CMP0: cap_fall = cmp_fall;
          default: cap_fall = clu_fall[i];
        endcase
        case (rsel_q)
          2'h1: frc = clu_out[0];
          2'h2: frc = clu_out[1];
          2'h3: frc = clu_out[2];
          default: frc = 1'b0;
        endcase
      end

      always @* begin
        cnt_d = cnt_q;
        rld_d = rld_q;
        hset = 1'b0;
        lset = 1'b0;
        ovf_d = 1'b0;
        if (split_q) begin
          if (tick_lo) begin
            if (cnt_q[7:0] == `RCT_BYTE_MAX) begin
              cnt_d[7:0] = rld_q[7:0];
              lset = 1'b1;
            end else begin
              cnt_d[7:0] = cnt_q[7:0] + 8'h01;
            end
          end
          if (run_q & tick_hi) begin
            if (cnt_q[15:8] == `RCT_BYTE_MAX) begin
              cnt_d[15:8] = rld_q[15:8];
              hset = 1'b1;
              ovf_d = 1'b1;
            end else begin
              cnt_d[15:8] = cnt_q[15:8] + 8'h01;
            end
          end
        end else if (run_q) begin
          if (frc & ~cap_en_q) begin
            cnt_d = rld_q;
          end else if (tick_lo) begin
            if (cnt_q[7:0] == `RCT_BYTE_MAX) begin
              lset = 1'b1;
            end
            if (cnt_q == `RCT_WORD_MAX) begin
              ovf_d = 1'b1;
              if (cap_en_q) begin
                cnt_d = `RCT_COUNT_RESET;
              end else begin
                cnt_d = rld_q;
                hset = 1'b1;
              end
            end else begin
              cnt_d = cnt_q + 16'h0001;
            end
          end
        end
        if (cap_hit) begin
          rld_d = cnt_q;
          hset = 1'b1;
        end
      end

      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_q <= `RCT_COUNT_RESET;
          rld_q <= `RCT_COUNT_RESET;
          hflag_q <= 1'b0;
          lflag_q <= 1'b0;
          lo_irq_en_q <= 1'b0;
          cap_en_q <= 1'b0;
          split_q <= 1'b0;
          run_q <= 1'b0;
          xsel_q <= 2'h0;
          csel_q <= 2'h0;
          rsel_q <= 2'h0;
          lsel_q <= 1'b0;
          hsel_q <= 1'b0;
          tirq_en_q <= 1'b0;
          ovf_q <= 1'b0;
          irq_q <= 1'b0;
        end else begin
          cnt_q <= w_cnt ? hwdata[15:0] : cnt_d;
          // a capture in the same cycle beats a software write
          rld_q <= (w_rld & ~cap_hit) ? hwdata[15:0] : rld_d;
          // set wins over a software clear
          hflag_q <= hset | (w_c0 ? hwdata[`RCT_C0_HIGH_FLAG] : hflag_q);
          lflag_q <= lset | (w_c0 ? hwdata[`RCT_C0_LOW_FLAG] : lflag_q);
          ovf_q <= ovf_d;
          irq_q <= tirq_en_q & (hflag_q | (lo_irq_en_q & lflag_q));
          if (w_c0) begin
            lo_irq_en_q <= hwdata[`RCT_C0_LOW_IRQ_EN];
            cap_en_q <= hwdata[`RCT_C0_CAPTURE_EN];
            split_q <= hwdata[`RCT_C0_SPLIT];
            run_q <= hwdata[`RCT_C0_RUN];
            xsel_q <= hwdata[`RCT_C0_XCLK_LSB +: 2];
          end
          if (w_c1) begin
            csel_q <= hwdata[`RCT_C1_CSEL_LSB +: 2];
            rsel_q <= hwdata[`RCT_C1_FORCED_RELOAD_SELECT_LSB +: 2];
            lsel_q <= hwdata[`RCT_C1_LOW_HALF_SEL];
            hsel_q <= hwdata[`RCT_C1_HIGH_HALF_SEL];
            tirq_en_q <= hwdata[`RCT_C1_TIMER_IRQ_EN];
          end
        end
      end

      assign ovf_all[i] = ovf_q;
      assign timer_irq[i] = irq_q;
      assign cnt_all[16*i +: 16] = cnt_q;
      assign rld_all[16*i +: 16] = rld_q;
      assign c0_all[8*i +: 8] = {hflag_q, lflag_q, lo_irq_en_q, cap_en_q, split_q, run_q, xsel_q};
      assign c1_all[8*i +: 8] = {1'b0, tirq_en_q, hsel_q, lsel_q, rsel_q, csel_q};
    end
  endgenerate

  assign timer_overflow = ovf_all;

  // wake only when the wake timer's low half runs from the slow oscillator, directly or via the partner
  wire wake_direct = (c0_all[9:8] == `RCT_XCLK_LFO_DIV8) & ~c1_all[8 + `RCT_C1_LOW_HALF_SEL];
  wire partner_slow = (c0_all[1:0] == `RCT_XCLK_LFO_DIV8) & ~c1_all[`RCT_C1_LOW_HALF_SEL];
  wire wake_chain = (c0_all[9:8] == `RCT_XCLK_PARTNER) & ~c1_all[8 + `RCT_C1_LOW_HALF_SEL] & partner_slow;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= low_power_mode & ovf_all[1] & (wake_direct | wake_chain);
    end
  end

endmodule

// two-flop synchroniser with a third stage for edge detection
module rct_sync_edge (
  input wire clk, // sampling clock
  input wire rst_n, // asynchronous reset, active low
  input wire async_in, // level from another clock domain
  output wire rise, // one-cycle pulse on a rising edge
  output wire fall // one-cycle pulse on a falling edge
);

  reg [2:0] sync_q;

  // only the second stage reads the first
  assign rise = sync_q[1] & ~sync_q[2];
  assign fall = ~sync_q[1] & sync_q[2];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], async_in};
    end
  end

endmodule

// ---- design/rct_defines.vh ----
// register map, field positions, reset values and divider counts of the reload/capture timer pair
`ifndef RCT_DEFINES_VH
`define RCT_DEFINES_VH

// word index of each register inside one timer's 16-byte window (byte address = 4 * index)
`define RCT_REG_CTRL0 2'h0
`define RCT_REG_CTRL1 2'h1
`define RCT_REG_COUNT 2'h2
`define RCT_REG_RELOAD 2'h3
// byte address bit that picks the timer: 0x00 partner timer, 0x10 wake-capable timer
`define RCT_TIMER_BIT 4

// timer_control_zero fields
`define RCT_C0_HIGH_FLAG 7
`define RCT_C0_LOW_FLAG 6
`define RCT_C0_LOW_IRQ_EN 5
`define RCT_C0_CAPTURE_EN 4
`define RCT_C0_SPLIT 3
`define RCT_C0_RUN 2
`define RCT_C0_XCLK_LSB 0
// timer_control_one fields
`define RCT_C1_CSEL_LSB 0
`define RCT_C1_FORCED_RELOAD_SELECT_LSB 2
`define RCT_C1_LOW_HALF_SEL 4
`define RCT_C1_HIGH_HALF_SEL 5
`define RCT_C1_TIMER_IRQ_EN 6
`define RCT_CTRL_RESET 8'h00
`define RCT_COUNT_RESET 16'h0000

// ext_clock_select codes
`define RCT_XCLK_SYS_DIV12 2'h0
`define RCT_XCLK_EXT_DIV8 2'h1
`define RCT_XCLK_PARTNER 2'h2
`define RCT_XCLK_LFO_DIV8 2'h3
// capture_source_select codes
`define RCT_CSEL_PIN 2'h0
`define RCT_CSEL_LFO 2'h1
`define RCT_CSEL_CMP0 2'h2
`define RCT_CSEL_CLU 2'h3

// divider terminal counts
`define RCT_SYS_DIV 12
`define RCT_SLOW_DIV 8
`define RCT_DIV12_LAST 4'hB
`define RCT_DIV8_LAST 3'h7
`define RCT_BYTE_MAX 8'hFF
`define RCT_WORD_MAX 16'hFFFF

`endif

// ---- tb/rct_asserts.sv ----
// bus, interrupt and wake checks for the timer pair
`timescale 1ns/10ps
module rct_asserts (
  input logic hclk, // clock
  input logic hresetn, // reset, active low
  input logic hsel, // select
  input logic [7:0] haddr, // address
  input logic [1:0] htrans, // transfer type
  input logic hwrite, // write
  input logic hready, // bus ready
  input logic hreadyout, // slave ready
  input logic hresp, // response
  input logic [31:0] hrdata, // read data
  input logic low_power_mode, // suspend or snooze
  input logic [1:0] timer_irq, // interrupts
  input logic [1:0] timer_overflow, // overflow pulses
  input logic wake_req // wake pulse
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic [1:0] rd_sh, un_sh;
  logic [2:0] wr_sh;
  assign take = hsel && hready && htrans[1];
  // pipeline of taken transfers, to know which cycle is a data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_sh <= 2'h0;
      un_sh <= 2'h0;
      wr_sh <= 3'h0;
    end else begin
      rd_sh <= {rd_sh[0], take && !hwrite};
      un_sh <= {un_sh[0], haddr[7:5] != 3'h0 || haddr[1:0] != 2'h0};
      wr_sh <= {wr_sh[1:0], take && hwrite};
    end
  end
  property p_hresp_okay; hresp == 1'b0; endproperty
  a_hresp_okay: assert property (p_hresp_okay) else $error("response not okay");
  property p_ready_wait; hreadyout == !rd_sh[0]; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("wait state misplaced");
  property p_read_upper; rd_sh[1] |-> hrdata[31:16] == 16'h0000; endproperty
  a_read_upper: assert property (p_read_upper) else $error("upper read bits set");
  property p_unmapped_zero; rd_sh[1] && un_sh[1] |-> hrdata == 32'h00000000; endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_rd_stands; !rd_sh[0] && !rd_sh[1] |-> $stable(hrdata); endproperty
  a_rd_stands: assert property (p_rd_stands) else $error("read data moved");
  property p_wake_cause; wake_req |-> $past(timer_overflow[1]); endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without overflow");
  property p_wake_lpm; wake_req |-> $past(low_power_mode); endproperty
  a_wake_lpm: assert property (p_wake_lpm) else $error("wake outside low power");
  property p_irq_sticky; |($past(timer_irq) & ~timer_irq) |-> |wr_sh; endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt dropped alone");
  c_wake: cover property (wake_req);
  c_ovf: cover property (timer_overflow[0]);
  c_unmapped: cover property (rd_sh[1] && un_sh[1]);
endmodule
bind rct16_timer rct_asserts rct_asserts_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .low_power_mode(low_power_mode), .timer_irq(timer_irq),
  .timer_overflow(timer_overflow), .wake_req(wake_req));

// ---- tb/reload_capture_timer16_tb_top.sv ----
// self-checking bench for the reload/capture timer pair
`timescale 1ns/10ps
module reload_capture_timer16_tb_top;
  logic hclk, hresetn, hsel, hwrite, ext_clk_in, lfo_clk_in, cmp0_event, low_power_mode, rdy;
  logic [7:0] haddr;
  logic [1:0] htrans, capture_pin;
  logic [2:0] hsize;
  logic [3:0] clu_out;
  logic [31:0] hwdata, rdat;
  wire hready, hreadyout, hresp, wake_req;
  wire [31:0] hrdata;
  wire [1:0] timer_irq, timer_overflow;
  int fails, comparisons, n;
  assign hready = hreadyout;
  rct16_timer rct16_timer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_clk_in(ext_clk_in),
    .lfo_clk_in(lfo_clk_in), .capture_pin(capture_pin), .cmp0_event(cmp0_event), .clu_out(clu_out),
    .low_power_mode(low_power_mode), .timer_irq(timer_irq), .timer_overflow(timer_overflow),
    .wake_req(wake_req));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // slow oscillator stand-in, one period every four clock cycles
  logic [1:0] lfo_cnt = 2'h0;
  always @(posedge hclk) begin
    lfo_cnt <= lfo_cnt + 2'h1;
    lfo_clk_in <= lfo_cnt[1];
  end
  // bus answers are sampled mid-cycle, where they are settled
  always @(negedge hclk) begin
    rdy = hreadyout;
    rdat = hrdata;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (rdy !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (rdy !== 1'b1) @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    xfer(1'b0, a, 32'h00000000);
    chk(rdat, e, m);
  endtask
  task automatic irq_after(input logic [7:0] c0, input logic e);
    wr(8'h00, c0);
    repeat (2) @(posedge hclk);
    chk(timer_irq[0], e, "irq");
  endtask
  task automatic t_basic;
    rd(8'h00, 32'h0, "ctrl0 reset");
    wr(8'h20, 32'hFF);
    rd(8'h20, 32'h0, "unmapped");
    wr(8'h04, 32'h10);
    wr(8'h08, 32'h0100);
    repeat (5) @(posedge hclk);
    rd(8'h08, 32'h0100, "held count");
  endtask
  task automatic t_ovf;
    wr(8'h0C, 32'h1234);
    wr(8'h08, 32'hFFF0);
    wr(8'h04, 32'h50);
    wr(8'h00, 32'h04);
    wait (timer_overflow[0] === 1'b1);
    @(posedge hclk);
    rd(8'h00, 32'hC4, "flags");
    chk(timer_irq[0], 1, "irq");
    wr(8'h00, 32'hC0);
    xfer(1'b0, 8'h08, 32'h0);
    chk(rdat[15:8], 32'h12, "reloaded");
    irq_after(8'h00, 1'b0);
    irq_after(8'h60, 1'b1);
    irq_after(8'h40, 1'b0);
  endtask
  task automatic t_split;
    wr(8'h14, 32'h70);
    wr(8'h1C, 32'h0010);
    wr(8'h18, 32'h05FD);
    wr(8'h10, 32'h08);
    repeat (12) @(posedge hclk);
    rd(8'h10, 32'h48, "split flags");
    chk(timer_irq[1], 0, "split irq");
    wr(8'h10, 32'h68);
    repeat (2) @(posedge hclk);
    chk(timer_irq[1], 1, "split low irq");
    wr(8'h10, 32'h0);
    xfer(1'b0, 8'h18, 32'h0);
    chk(rdat[15:8], 32'h05, "high held");
    chk(rdat[7:0] >= 8'h10, 1, "low reloaded");
  endtask
  task automatic t_forced;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h14);
    wr(8'h0C, 32'h0055);
    wr(8'h08, 32'h0);
    clu_out <= 4'h1;
    wr(8'h00, 32'h04);
    repeat (4) @(posedge hclk);
    wr(8'h00, 32'h0);
    clu_out <= 4'h0;
    rd(8'h08, 32'h0055, "forced reload");
  endtask
  task automatic t_capture;
    wr(8'h04, 32'h10);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h14);
    repeat (8) @(posedge hclk);
    capture_pin <= 2'h2;
    repeat (6) @(posedge hclk);
    rd(8'h00, 32'h94, "capture flag");
    xfer(1'b0, 8'h0C, 32'h0);
    chk(rdat > 32'h8 && rdat < 32'h20, 1, "captured");
    wr(8'h00, 32'h0);
    capture_pin <= 2'h3;
  endtask
  task automatic t_chain;
    wr(8'h04, 32'h00);
    wr(8'h0C, 32'hFFFE);
    wr(8'h08, 32'hFFFE);
    wr(8'h14, 32'h0);
    wr(8'h1C, 32'hFFFC);
    wr(8'h18, 32'hFFFC);
    low_power_mode <= 1'b1;
    wr(8'h10, 32'h06);
    wr(8'h00, 32'h07);
    @(negedge hclk);
    while (wake_req !== 1'b1) @(negedge hclk);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (wake_req !== 1'b1);
    // 4 clocks per slow period, /8, 2 partner ticks per overflow, 4 partner overflows per wake
    chk(n, 256, "chained period");
    @(posedge hclk);
    low_power_mode <= 1'b0;
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h0);
  endtask
  task automatic complete_run;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ext_clk_in = 1'b0;
    cmp0_event = 1'b0;
    capture_pin = 2'h3;
    clu_out = 4'h0;
    low_power_mode = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_basic;
    t_ovf;
    t_split;
    t_forced;
    t_capture;
    t_chain;
    complete_run;
  end
  initial begin
    #200000;
    fails++;
    complete_run;
  end
endmodule
